// [design/flash_req_arbiter.v]
// Request arbiter choosing between CPU and debug port requesters
`include "flash_seq_map.vh"
module flash_req_arbiter (
    input  wire                      cpu_req_in,
    input  wire [`FS_CMD_W-1:0]      cpu_cmd_in,
    input  wire [`FS_ADDR_W-1:0]     cpu_addr_in,
    input  wire [15:0]               cpu_data_in,
    input  wire                      dbg_req_in,
    input  wire [`FS_CMD_W-1:0]      dbg_cmd_in,
    input  wire [`FS_ADDR_W-1:0]     dbg_addr_in,
    input  wire [15:0]               dbg_data_in,
    output wire                      sel_req_out,
    output wire                      sel_dbg_out,
    output wire [`FS_CMD_W-1:0]      sel_cmd_out,
    output wire [`FS_ADDR_W-1:0]     sel_addr_out,
    output wire [15:0]               sel_data_out
);
    // Debug port wins a tie: it may be halting a runaway CPU
    assign sel_dbg_out  = dbg_req_in;
    assign sel_req_out  = cpu_req_in | dbg_req_in;
    assign sel_cmd_out  = dbg_req_in ? dbg_cmd_in : cpu_cmd_in;
    assign sel_addr_out = dbg_req_in ? dbg_addr_in : cpu_addr_in;
    assign sel_data_out = dbg_req_in ? dbg_data_in : cpu_data_in;
endmodule // flash_req_arbiter

// [design/flash_segment_program_erase.v]
// Flash program and erase sequencer with segment A lock
`include "flash_seq_map.vh"
module flash_segment_program_erase (
    input  wire                      clk_sys_in,
    input  wire                      sys_rst_in,
    input  wire                      cpu_req_in,      // One-cycle request pulse
    input  wire [`FS_CMD_W-1:0]      cpu_cmd_in,
    input  wire [`FS_ADDR_W-1:0]     cpu_addr_in,
    input  wire [15:0]               cpu_data_in,
    input  wire                      dbg_req_in,
    input  wire [`FS_CMD_W-1:0]      dbg_cmd_in,
    input  wire [`FS_ADDR_W-1:0]     dbg_addr_in,
    input  wire [15:0]               dbg_data_in,
    input  wire                      unlock_a_in,     // Pulse: clears segment A lock
    input  wire                      lock_a_in,       // Pulse: sets segment A lock
    output wire                      busy_out,
    output wire                      lock_a_out,
    output reg                       done_out,        // One-cycle, op finished
    output reg                       refused_out,     // One-cycle, request dropped
    output reg                       arr_we_out,      // Array write strobe
    output reg                       arr_byte_out,    // High for byte write
    output reg  [`FS_ADDR_W-1:0]     arr_addr_out,
    output reg  [15:0]               arr_data_out,
    output reg                       arr_erase_out,   // Array erase strobe
    output reg  [`FS_ADDR_W-1:0]     arr_erase_base_out,
    output reg  [`FS_ADDR_W-1:0]     arr_erase_last_out
);
    // One-hot sequencer states
    // One-hot codes keep each state test down to a single flop
    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_PROG  = 4'h2;
    localparam [3:0] ST_ERASE = 4'h4;
    localparam [3:0] ST_DONE  = 4'h8;
    // Program time in cycles, cut to the timer width on purpose
    localparam integer PROG_CYC_I = `FS_PROG_CYC;
    localparam [7:0]   PROG_CYC   = PROG_CYC_I[7:0];

    wire                  sel_req;           // Merged request
    wire [`FS_CMD_W-1:0]  sel_cmd;
    wire [`FS_ADDR_W-1:0] sel_addr;
    wire [15:0]           sel_data;
    reg  [3:0]            state_q;           // Sequencer state
    reg  [3:0]            state_d;
    reg  [7:0]            timer_q;           // Operation cycle timer
    reg  [7:0]            timer_d;
    reg                   lock_a_q;          // Segment A lock flag

    flash_req_arbiter u_arb (
        .cpu_req_in   (cpu_req_in),
        .cpu_cmd_in   (cpu_cmd_in),
        .cpu_addr_in  (cpu_addr_in),
        .cpu_data_in  (cpu_data_in),
        .dbg_req_in   (dbg_req_in),
        .dbg_cmd_in   (dbg_cmd_in),
        .dbg_addr_in  (dbg_addr_in),
        .dbg_data_in  (dbg_data_in),
        .sel_req_out  (sel_req),
        .sel_dbg_out  (),            // Who asked does not change the work
        .sel_cmd_out  (sel_cmd),
        .sel_addr_out (sel_addr),
        .sel_data_out (sel_data)
    );

    // True when an address falls in the locked calibration segment
    function in_seg_a;
        input [`FS_ADDR_W-1:0] a;
        begin
            in_seg_a = ((a & `FS_INFO_SEG_MASK) == `FS_SEGA_BASE);
        end
    endfunction

    // True when an address falls in the information area
    function in_info;
        input [`FS_ADDR_W-1:0] a;
        begin
            in_info = (a >= `FS_INFO_BASE) && (a <= `FS_INFO_LAST);
        end
    endfunction

    // Decide whether a request touches segment A at all
    // Mass erase spans segment A, so a held lock refuses it whole
    function hits_a;
        input [`FS_CMD_W-1:0]  c;
        input [`FS_ADDR_W-1:0] a;
        begin
            case (c)
                `FS_CMD_ERASE_MASS: hits_a = 1'b1;
                `FS_CMD_ERASE_MAIN: hits_a = 1'b0;
                default:            hits_a = in_seg_a(a);
            endcase
        end
    endfunction

    // Acceptance is decided in the request cycle itself: a request that
    // arrives while busy, aims at a locked segment A or carries an unknown
    // code gets a refused pulse instead of a queue slot, since requesters
    // send one-cycle pulses and hold nothing for a later retry
    wire cmd_ok  = (sel_cmd >= `FS_CMD_PROG_BYTE) && (sel_cmd <= `FS_CMD_ERASE_MASS);
    wire blocked = lock_a_q && hits_a(sel_cmd, sel_addr);
    wire start   = sel_req && (state_q == ST_IDLE) && cmd_ok && !blocked;

    // Busy is decoded from state so a requester sees it in the first op cycle
    assign busy_out   = (state_q != ST_IDLE);
    assign lock_a_out = lock_a_q;

    // Next state and timer
    // The timer reloads only on a start, so no stale count leaks into an op
    always @* begin
        state_d = state_q;
        timer_d = timer_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    if (sel_cmd == `FS_CMD_PROG_BYTE || sel_cmd == `FS_CMD_PROG_WORD) begin
                        state_d = ST_PROG;
                        timer_d = PROG_CYC;
                    end else begin
                        state_d = ST_ERASE;
                        timer_d = `FS_ERASE_STEP_CYC;
                    end
                end
            end
            ST_PROG, ST_ERASE: begin
                // Count down; no new start accepted meanwhile
                if (timer_q == 8'h01) begin
                    state_d = ST_DONE;
                end
                timer_d = timer_q - 8'h01;
            end
            ST_DONE: begin
                // One closing cycle lets done_out line up with busy falling
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State registers
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
            timer_q <= 8'h00;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
        end
    end

    // Segment A lock: set by reset, cleared only by software
    // Lock and unlock in one cycle leave the segment shut, the safe side,
    // and any reset pulse, however short, closes it again
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lock_a_q <= 1'b1;
        end else if (lock_a_in) begin
            lock_a_q <= 1'b1;                                       // Relock wins over unlock
        end else if (unlock_a_in) begin
            lock_a_q <= 1'b0;
        end
    end

    // Array strobes and status pulses, all registered
    // Strobes rest low through reset so a reset never writes or erases
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            arr_we_out         <= 1'b0;
            arr_byte_out       <= 1'b0;
            arr_addr_out       <= 16'h0000;
            arr_data_out       <= 16'h0000;
            arr_erase_out      <= 1'b0;
            arr_erase_base_out <= 16'h0000;
            arr_erase_last_out <= 16'h0000;
            done_out           <= 1'b0;
            refused_out        <= 1'b0;
        end else begin
            arr_we_out    <= 1'b0;
            arr_erase_out <= 1'b0;
            done_out      <= (state_q == ST_DONE);
            // Requests while busy, locked or malformed are dropped
            refused_out   <= sel_req && !start;
            if (start) begin
                case (sel_cmd)
                    `FS_CMD_PROG_BYTE: begin
                        arr_we_out   <= 1'b1;
                        arr_byte_out <= 1'b1;
                        arr_addr_out <= sel_addr;
                        arr_data_out <= {8'h00, sel_data[7:0]};
                    end
                    `FS_CMD_PROG_WORD: begin
                        // Word writes align to even bytes
                        arr_we_out   <= 1'b1;
                        arr_byte_out <= 1'b0;
                        arr_addr_out <= {sel_addr[15:1], 1'b0};
                        arr_data_out <= sel_data;
                    end
                    `FS_CMD_ERASE_SEG: begin
                        arr_erase_out <= 1'b1;
                        if (in_info(sel_addr)) begin
                            // One 64-byte information segment
                            arr_erase_base_out <= sel_addr & `FS_INFO_SEG_MASK;
                            arr_erase_last_out <= sel_addr | ~`FS_INFO_SEG_MASK;
                        end else begin
                            // One aligned 512-byte main segment
                            arr_erase_base_out <= sel_addr & `FS_MAIN_SEG_MASK;
                            arr_erase_last_out <= sel_addr | ~`FS_MAIN_SEG_MASK;
                        end
                    end
                    `FS_CMD_ERASE_MAIN: begin
                        arr_erase_out      <= 1'b1;
                        arr_erase_base_out <= `FS_MAIN_BASE;
                        arr_erase_last_out <= `FS_MAIN_LAST;
                    end
                    default: begin
                        // Mass erase: information plus main in one strobe
                        arr_erase_out      <= 1'b1;
                        arr_erase_base_out <= `FS_INFO_BASE;
                        arr_erase_last_out <= `FS_MAIN_LAST;
                    end
                endcase
            end
        end
    end
endmodule // flash_segment_program_erase

// [design/flash_seq_map.vh]
// Constants for the flash program and erase sequencer
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH
`define FS_ADDR_W        16
`define FS_MAIN_SEG_BYTES 16'h0200
`define FS_MAIN_SEG_MASK 16'hfe00
`define FS_INFO_SEG_MASK 16'hffc0
`define FS_INFO_BASE     16'h1000
`define FS_INFO_LAST     16'h10ff
`define FS_SEGA_BASE     16'h10c0
`define FS_MAIN_BASE     16'hf000
`define FS_MAIN_LAST     16'hffff
`define FS_OSC_CAL_ADDR  16'h10f6
`define FS_OSC_CAL_TAG   8'h01
`define FS_CONV_CAL_ADDR 16'h10da
`define FS_CONV_CAL_TAG  8'h10
`define FS_EMPTY_TAG     8'hfe
`define FS_CMD_W         3
`define FS_CMD_PROG_BYTE 3'h1
`define FS_CMD_PROG_WORD 3'h2
`define FS_CMD_ERASE_SEG 3'h3
`define FS_CMD_ERASE_MAIN 3'h4
`define FS_CMD_ERASE_MASS 3'h5
`define FS_PROG_NS       1000
`define FS_PROG_CYC      ((`FS_PROG_NS + 49) / 50)
`define FS_ERASE_STEP_CYC 8'h04
`endif

// [sim/flash_req_model.sv]
// Requester model standing in for the processor or the debug port
module flash_req_model (
    input  wire logic        clk_sys_in,
    input  wire logic        go_in,
    input  wire logic [2:0]  cmd_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] data_in,
    output logic             req_out = 1'b0,
    output logic [2:0]       cmd_out = 3'h0,
    output logic [15:0]      addr_out = 16'h0,
    output logic [15:0]      data_out = 16'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // One-cycle request; fields are scrambled once it has passed, so stale values never help
    always @(posedge clk_sys_in) begin
        req_out <= go_in;
        cmd_out <= go_in ? cmd_in : ~cmd_out;
        addr_out <= go_in ? addr_in : ~addr_out;
        data_out <= go_in ? data_in : ~data_out;
    end
endmodule // flash_req_model

// [sim/flash_seq_assertions.sv]
// Port-level checks for the flash program and erase sequencer
`include "flash_seq_map.vh"
module flash_seq_checker (
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic        cpu_req_in,
    input wire logic [2:0]  cpu_cmd_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic        dbg_req_in,
    input wire logic [2:0]  dbg_cmd_in,
    input wire logic [15:0] dbg_addr_in,
    input wire logic        unlock_a_in,
    input wire logic        lock_a_in,
    input wire logic        busy_out,
    input wire logic        lock_a_out,
    input wire logic        done_out,
    input wire logic        refused_out,
    input wire logic        arr_we_out,
    input wire logic        arr_byte_out,
    input wire logic [15:0] arr_addr_out,
    input wire logic        arr_erase_out,
    input wire logic [15:0] arr_erase_base_out,
    input wire logic [15:0] arr_erase_last_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // Debug port wins a tie, so follow its fields when it asks
    wire [2:0]  c = dbg_req_in ? dbg_cmd_in : cpu_cmd_in;
    wire [15:0] a = dbg_req_in ? dbg_addr_in : cpu_addr_in;
    wire        req = cpu_req_in | dbg_req_in;
    wire        info = (a[15:8] == 8'h10);
    // Mass erase reaches segment A; erase of all main never does
    wire blk = lock_a_out && (c == 3'h5 || (c != 3'h4 && a >= 16'h10c0 && info));
    wire take = req && !busy_out && c >= 3'h1 && c <= 3'h5 && !blk;
    sequence prog_run; busy_out [*8] ##13 busy_out; endsequence
    sequence erase_run; busy_out [*4] ##1 1'b1; endsequence
    lock_reset_a:
        assert property ($fell(sys_rst_in) |-> lock_a_out) else $error("lock low after reset");
    lock_ctl_a:
        assert property ((lock_a_in || unlock_a_in) |=> lock_a_out == $past(lock_a_in))
        else $error("lock control wrong");
    prog_a:
        assert property (take && c <= 3'h2 |=> arr_we_out && arr_byte_out == ($past(c) == 3'h1)
            && arr_addr_out == ($past(c) == 3'h1 ? $past(a) : $past(a) & 16'hfffe))
        else $error("program strobe wrong");
    main_seg_a:
        assert property (take && c == 3'h3 && !info |=> arr_erase_out && arr_erase_base_out ==
            ($past(a) & 16'hfe00) && arr_erase_last_out == ($past(a) | 16'h01ff))
        else $error("main segment range wrong");
    main_all_a:
        assert property (take && c == 3'h4 |=> arr_erase_out && arr_erase_base_out == 16'hf000
            && arr_erase_last_out == 16'hffff) else $error("main erase range wrong");
    mass_all_a:
        assert property (take && c == 3'h5 |=> arr_erase_out && arr_erase_base_out == 16'h1000
            && arr_erase_last_out == 16'hffff) else $error("mass erase range wrong");
    info_seg_a:
        assert property (take && c == 3'h3 && info |=> arr_erase_out && arr_erase_base_out ==
            ($past(a) & 16'hffc0) && arr_erase_last_out == ($past(a) | 16'h003f))
        else $error("info segment range wrong");
    refuse_a:
        assert property (req && !take |=> refused_out && !arr_we_out && !arr_erase_out)
        else $error("request not refused");
    prog_time_a:
        assert property (take && c <= 3'h2 |=> prog_run ##1 (done_out && !busy_out))
        else $error("program timing wrong");
    erase_time_a:
        assert property (take && c >= 3'h3 |=> erase_run ##1 (done_out && !busy_out))
        else $error("erase timing wrong");
endmodule // flash_seq_checker
bind flash_segment_program_erase flash_seq_checker flash_seq_checker_i (.*);

// [sim/tb.sv]
// Self-checking bench for the flash program and erase sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, unlock_a_in = 1'b0, lock_a_in = 1'b0;
    logic cgo = 1'b0, dgo = 1'b0, cpu_req_in, dbg_req_in, busy_out, lock_a_out, done_out;
    logic refused_out, arr_we_out, arr_byte_out, arr_erase_out;
    logic [2:0] gcmd = 3'h0, cpu_cmd_in, dbg_cmd_in;
    logic [15:0] gaddr = 16'h0, gdata = 16'h0, cpu_addr_in, dbg_addr_in, cpu_data_in, dbg_data_in;
    logic [15:0] arr_addr_out, arr_data_out, arr_erase_base_out, arr_erase_last_out;
    logic [35:0] notes[$]; // Expected events: kind, then two fields
    int err_total = 0, cmp_count = 0, cyc = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    flash_segment_program_erase flash_segment_program_erase_i (.*);
    flash_req_model cpu_side_i (.clk_sys_in, .go_in(cgo), .cmd_in(gcmd), .addr_in(gaddr),
        .data_in(gdata), .req_out(cpu_req_in), .cmd_out(cpu_cmd_in), .addr_out(cpu_addr_in),
        .data_out(cpu_data_in));
    flash_req_model dbg_side_i (.clk_sys_in, .go_in(dgo), .cmd_in(gcmd), .addr_in(gaddr),
        .data_in(gdata), .req_out(dbg_req_in), .cmd_out(dbg_cmd_in), .addr_out(dbg_addr_in),
        .data_out(dbg_data_in));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Issue one request through a requester model; optionally wait until idle again
    task automatic op(input bit dbg, input logic [2:0] c, input logic [15:0] a,
                      input logic [15:0] d, input logic [35:0] exp, input bit hold);
        @(posedge clk_sys_in);
        gcmd <= c;
        gaddr <= a;
        gdata <= d;
        if (dbg) dgo <= 1'b1;
        else cgo <= 1'b1;
        notes.push_back(exp);
        @(posedge clk_sys_in);
        dgo <= 1'b0;
        cgo <= 1'b0;
        for (int i = 0; hold && i < 40 && (busy_out || !(done_out || refused_out)); i++)
            @(posedge clk_sys_in);
    endtask
    // Every strobe or refusal retires the oldest note, ranges and data included
    always @(posedge clk_sys_in) begin
        logic [35:0] got, want;
        got = 36'h0;
        want = 36'h0;
        cyc++;
        if (arr_we_out) got = {arr_byte_out ? 4'h1 : 4'h2, arr_addr_out, arr_data_out};
        if (arr_erase_out) got = {4'h3, arr_erase_base_out, arr_erase_last_out};
        if (refused_out) got = {4'h5, 32'h0};
        if (got != 36'h0) begin
            if (notes.size() > 0) want = notes.pop_front();
            chk(got, want);
        end
        if (cyc == 6000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        logic [15:0] r, d;
        void'($urandom(70));
        repeat (12) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        chk({35'h0, lock_a_out}, 36'h1);
        // Segment A stays shut after reset, mass erase too; erase of all main still goes
        op(0, 3'h1, 16'h10f6, 16'h00a5, {4'h5, 32'h0}, 1);
        op(1, 3'h3, 16'h10da, 16'h0000, {4'h5, 32'h0}, 1);
        op(0, 3'h5, 16'hf000, 16'h0000, {4'h5, 32'h0}, 1);
        op(1, 3'h4, 16'h1234, 16'h0000, {4'h3, 16'hf000, 16'hffff}, 1);
        $display("test locked_after_reset done");
        // Both requesters program bytes and words and erase main and information segments
        for (int i = 0; i < 4; i++) begin
            r = {4'hf, 12'($urandom)};
            d = 16'($urandom);
            op(i[0], 3'h1, r, d, {4'h1, r, 8'h00, d[7:0]}, 1);
            op(!i[0], 3'h2, r, d, {4'h2, r & 16'hfffe, d}, 1);
            op(i[0], 3'h3, r, d, {4'h3, r & 16'hfe00, r | 16'h01ff}, 1);
        end
        for (int s = 0; s < 3; s++) begin
            r = 16'h1000 + 16'(s * 64) + 16'($urandom_range(63));
            op(s[0], 3'h3, r, 16'h0000, {4'h3, r & 16'hffc0, r | 16'h003f}, 1);
        end
        $display("test program_erase done");
        // Unknown commands, then a request that lands while busy
        op(0, 3'h0, 16'hf100, 16'h0000, {4'h5, 32'h0}, 1);
        op(1, 3'h6, 16'hf100, 16'h0000, {4'h5, 32'h0}, 1);
        op(0, 3'h7, 16'hf100, 16'h0000, {4'h5, 32'h0}, 1);
        op(0, 3'h1, 16'hf010, 16'h005a, {4'h1, 16'hf010, 16'h005a}, 0);
        op(1, 3'h1, 16'hf012, 16'h0033, {4'h5, 32'h0}, 1);
        $display("test refusals done");
        // Unlock opens segment A and mass erase; relock shuts it again
        @(posedge clk_sys_in);
        unlock_a_in <= 1'b1;
        @(posedge clk_sys_in);
        unlock_a_in <= 1'b0;
        op(1, 3'h2, 16'h10c3, 16'hbeef, {4'h2, 16'h10c2, 16'hbeef}, 1);
        // Calibration is not needed in this run, so erasing segment A is allowed
        op(0, 3'h5, 16'h0000, 16'h0000, {4'h3, 16'h1000, 16'hffff}, 1);
        // Mark the erased converter record slot as unused space
        op(1, 3'h1, 16'h10da, 16'h00fe, {4'h1, 16'h10da, 16'h00fe}, 1);
        @(posedge clk_sys_in);
        lock_a_in <= 1'b1;
        @(posedge clk_sys_in);
        lock_a_in <= 1'b0;
        op(0, 3'h3, 16'h10c0, 16'h0000, {4'h5, 32'h0}, 1);
        @(posedge clk_sys_in);
        chk({35'h0, lock_a_out}, 36'h1);
        $display("test unlock_relock done");
        // A reset in mid-run shuts segment A again after software opened it
        unlock_a_in <= 1'b1;
        @(posedge clk_sys_in);
        unlock_a_in <= 1'b0;
        @(posedge clk_sys_in);
        chk({35'h0, lock_a_out}, 36'h0);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        chk({35'h0, lock_a_out}, 36'h1);
        op(1, 3'h2, 16'h10f6, 16'h1234, {4'h5, 32'h0}, 1);
        @(posedge clk_sys_in);
        chk(36'(notes.size()), 36'h0);
        $display("test mid_run_reset done");
        test_done();
    end
endmodule // tb
